// >>> uib_pkg.sv
// package for the uart event and bit-rate control block
// assumes a 32-bit register port on core_clk with byte offsets as listed
package uib_pkg;
  localparam logic [11:0] EVENT_STATUS_OFFSET = 12'h000;
  localparam logic [11:0] EVENT_MASK_OFFSET = 12'h004;
  localparam logic [11:0] EVENT_CLEAR_OFFSET = 12'h008;
  localparam logic [11:0] BIT_RATE_DIVISORS_OFFSET = 12'h00c;
  localparam int EVENT_COUNT = 13;
  localparam logic [12:0] EVENT_MASK_RESET = 13'h1fff;
  localparam logic [31:0] BIT_RATE_DIVISORS_RESET = 32'h0000_0000;
  localparam int RTS_LEVEL_BIT = 12;
  localparam int CTS_LEVEL_BIT = 11;
  localparam logic [12:0] LATCHED_BITS = 13'h07ff;
  localparam int RX_DIV_LSB = 16;
  localparam int TX_DIV_LSB = 0;
  localparam int DIV_WIDTH = 16;
  localparam logic [15:0] DIV_MIN = 16'h0010;

  typedef struct packed {
    logic rx_push_error;
    logic parity_error;
    logic frame_error;
    logic bus_pop_error;
    logic bus_push_error;
    logic receive_full_event;
    logic receive_threshold_event;
    logic receive_nonempty_event;
    logic transmit_nonfull_event;
    logic transmit_space_event;
    logic transmit_empty_event;
  } uib_events_type;

  typedef struct packed {
    logic sel;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } uib_reg_req_type;
endpackage

// >>> uib_rate_div.sv
// divider that makes a one-cycle rate pulse from the reference clock
// assumes the divisor comes from a register in the same clock domain
`timescale 1ns/1ps
module uib_rate_div #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] divisor,
  output logic tick
);
  logic [WIDTH-1:0] count_reg;

  // refused at elaboration: a one-bit counter cannot hold a useful divisor
  if (WIDTH < 2) begin : g_width_check
    $error("uib_rate_div: WIDTH too small");
  end

  // zero divisor (reset value) holds the divider idle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else if (divisor == '0) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else if (count_reg >= divisor - 1'b1) begin
      count_reg <= '0;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// >>> uib_event_ctrl.sv
// uart event status, mask, clear and bit-rate divisor registers
// assumes event inputs are one-cycle pulses or levels on core_clk, modem lines async
//
// What this block does
// - all thirteen raw events are readable unmasked at the status offset.
// - the interrupt output is high when any raw event is set and not masked.
// - each event has a mask bit at its own position, one masks and zero passes.
// - all thirteen mask bits reset to one and bits 31 to 13 are reserved.
// - writing one to a clear bit resets that latched event; the clear register is write-only.
// - the receive rate is the reference clock divided by divisor bits 31 to 16.
// - the transmit rate is the reference clock divided by divisor bits 15 to 0.
// - receive error events set on parity error, missing stop bit and receive push error.
// - fifo flag events in bits 5 to 0 set on their fifo conditions.
`timescale 1ns/1ps
module uib_event_ctrl (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire uib_pkg::uib_reg_req_type reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  input wire uib_pkg::uib_events_type event_set,
  input wire logic rts_line,
  input wire logic cts_line,
  output logic irq_out,
  output logic rx_rate_tick,
  output logic tx_rate_tick,
  output logic [15:0] rx_divisor,
  output logic [15:0] tx_divisor,
  output logic divisor_invalid
);
  logic [10:0] latched_reg;
  logic [12:0] mask_reg;
  logic [31:0] divisors_reg;
  logic [1:0] rts_sync_reg;
  logic [1:0] cts_sync_reg;
  logic [12:0] status;
  logic [10:0] clear_bits;
  logic wr_clear;
  logic rx_tick;
  logic tx_tick;

  // modem lines are asynchronous: two flops before use
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rts_sync_reg <= 2'h0;
      cts_sync_reg <= 2'h0;
    end else begin
      rts_sync_reg <= {rts_sync_reg[0], rts_line};
      cts_sync_reg <= {cts_sync_reg[0], cts_line};
    end
  end

  assign wr_clear = reg_req.sel && reg_req.write &&
                    reg_req.addr == uib_pkg::EVENT_CLEAR_OFFSET;
  assign clear_bits = wr_clear ? reg_req.wdata[10:0] : 11'h000;
  // modem bits come from the synchronised lines; writes there are dropped
  assign status = {rts_sync_reg[1], cts_sync_reg[1], latched_reg};

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      latched_reg <= 11'h000;
    end else begin
      latched_reg <= (latched_reg & ~clear_bits) | event_set;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= uib_pkg::EVENT_MASK_RESET;
    end else if (reg_req.sel && reg_req.write &&
                 reg_req.addr == uib_pkg::EVENT_MASK_OFFSET) begin
      mask_reg <= reg_req.wdata[12:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      divisors_reg <= uib_pkg::BIT_RATE_DIVISORS_RESET;
    end else if (reg_req.sel && reg_req.write &&
                 reg_req.addr == uib_pkg::BIT_RATE_DIVISORS_OFFSET) begin
      divisors_reg <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status & ~mask_reg);
    end
  end

  // read port: one-cycle ack, unmapped and write-only offsets read zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= reg_req.sel;
      if (reg_req.sel && !reg_req.write) begin
        unique case (reg_req.addr)
          uib_pkg::EVENT_STATUS_OFFSET: reg_rdata <= {19'h0_0000, status};
          uib_pkg::EVENT_MASK_OFFSET: reg_rdata <= {19'h0_0000, mask_reg};
          uib_pkg::BIT_RATE_DIVISORS_OFFSET: reg_rdata <= divisors_reg;
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  uib_rate_div #(.WIDTH(uib_pkg::DIV_WIDTH)) u_rx_div (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .divisor(divisors_reg[31:16]),
    .tick(rx_tick)
  );

  uib_rate_div #(.WIDTH(uib_pkg::DIV_WIDTH)) u_tx_div (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .divisor(divisors_reg[15:0]),
    .tick(tx_tick)
  );

  // flags divisor settings below sixteen; infrared equality is left to software
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_rate_tick <= 1'b0;
      tx_rate_tick <= 1'b0;
      rx_divisor <= 16'h0000;
      tx_divisor <= 16'h0000;
      divisor_invalid <= 1'b1;
    end else begin
      rx_rate_tick <= rx_tick;
      tx_rate_tick <= tx_tick;
      rx_divisor <= divisors_reg[31:16];
      tx_divisor <= divisors_reg[15:0];
      divisor_invalid <= divisors_reg[31:16] < uib_pkg::DIV_MIN ||
                         divisors_reg[15:0] < uib_pkg::DIV_MIN;
    end
  end

  chk_irq_follows_unmasked: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ##1 irq_out == |($past(status) & ~$past(mask_reg)))
    else $error("irq output does not match unmasked status");
  chk_mask_reset_value: assert property (
    @(posedge core_clk) $rose(reset_n) |-> mask_reg == 13'h1fff)
    else $error("mask reset value wrong");
  chk_event_sets_latch: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    event_set.parity_error |=> latched_reg[9])
    else $error("parity event not latched");
  chk_fifo_flag_sets: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    event_set.transmit_empty_event |=> status[0])
    else $error("transmit empty event not latched");
  chk_latch_holds: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    latched_reg[3] && !clear_bits[3] |=> latched_reg[3])
    else $error("latched event lost without clear");
  chk_clear_one_works: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    clear_bits[8] && !event_set.frame_error |=> !latched_reg[8])
    else $error("clear did not reset event");
  chk_modem_level_track: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    rts_line ##1 rts_line |=> status[12])
    else $error("rts level not reflected");
  chk_status_read_raw: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    reg_req.sel && !reg_req.write && reg_req.addr == 12'h000
    |=> reg_rdata[12:0] == $past(status) && reg_ack)
    else $error("status read wrong");
  chk_rx_divider_period: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    rx_tick && $stable(divisors_reg) && divisors_reg[31:16] == 16'h0010
    |=> !rx_tick [*8] ##0 1)
    else $error("receive divider fires early");
  chk_tx_idle_zero: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    divisors_reg[15:0] == 16'h0000 ##1 divisors_reg[15:0] == 16'h0000 |-> !tx_tick)
    else $error("transmit divider runs at zero");
  chk_rx_idle_zero: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    divisors_reg[31:16] == 16'h0000 ##1 divisors_reg[31:16] == 16'h0000 |-> !rx_tick)
    else $error("receive divider runs at zero");
  chk_tx_divider_period: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    tx_tick && $stable(divisors_reg) && divisors_reg[15:0] == 16'h0015
    |=> !tx_tick [*8])
    else $error("transmit divider fires early");
  chk_mask_write_lands: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    reg_req.sel && reg_req.write && reg_req.addr == uib_pkg::EVENT_MASK_OFFSET
    |=> mask_reg == $past(reg_req.wdata[12:0]))
    else $error("mask write not stored");
  chk_irq_quiet_masked: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    mask_reg == uib_pkg::EVENT_MASK_RESET |=> !irq_out)
    else $error("irq raised while all sources masked");
  chk_cts_level_track: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    cts_line ##1 cts_line |=> status[11])
    else $error("cts level not reflected");
  chk_rts_low_track: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !rts_line ##1 !rts_line |=> !status[12])
    else $error("rts low level not reflected");
  chk_invalid_below_min: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    divisors_reg[15:0] < uib_pkg::DIV_MIN |=> divisor_invalid)
    else $error("short transmit divisor not flagged");

  cov_irq_raised: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(irq_out));
  cov_clear_write: cover property (@(posedge core_clk) disable iff (!reset_n) wr_clear);
  cov_rx_tick: cover property (@(posedge core_clk) disable iff (!reset_n) rx_tick);
  cov_set_and_clear: cover property (@(posedge core_clk) disable iff (!reset_n)
    clear_bits[0] && event_set.transmit_empty_event);
endmodule

// >>> uib_host_model.sv
// host software model: drives register requests and takes the answers
// assumes one request per sel cycle, answer one cycle later
`timescale 1ns/1ps
module uib_host_model (
  input wire logic core_clk,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata,
  output uib_pkg::uib_reg_req_type reg_req
);
  initial reg_req = '0;
  task automatic access(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic ok);
    @(negedge core_clk);
    reg_req = '{sel: 1'b1, write: wr, addr: a, wdata: d};
    @(negedge core_clk);
    ok = reg_ack;
    q = reg_rdata;
    // released fields no longer show the last value
    reg_req = '{sel: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
  endtask
endmodule

// >>> tb.sv
// testbench for the uart event and bit-rate control block
// assumes the host model drives the register port
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic rts_line = 1'b0;
  logic cts_line = 1'b0;
  uib_pkg::uib_reg_req_type reg_req;
  uib_pkg::uib_events_type event_set = '0;
  logic [31:0] reg_rdata;
  logic reg_ack, irq_out, rx_rate_tick, tx_rate_tick, divisor_invalid;
  logic [15:0] rx_divisor, tx_divisor;
  int n_mismatch = 0;
  int checked = 0;
  logic [10:0] lat = '0;
  logic [12:0] mask = 13'h1fff;
  always #12.5 core_clk = ~core_clk;
  uib_host_model u_host (.core_clk(core_clk), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
    .reg_req(reg_req));
  uib_event_ctrl u_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .event_set(event_set), .rts_line(rts_line),
    .cts_line(cts_line), .irq_out(irq_out), .rx_rate_tick(rx_rate_tick),
    .tx_rate_tick(tx_rate_tick), .rx_divisor(rx_divisor), .tx_divisor(tx_divisor),
    .divisor_invalid(divisor_invalid));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    logic ok;
    u_host.access(1'b0, a, 32'h0, q, ok);
    chk("ack", 32'h1, {31'h0, ok});
    chk(nm, e, q);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic ok;
    u_host.access(1'b1, a, d, q, ok);
    chk("ack", 32'h1, {31'h0, ok});
  endtask
  task automatic gap(input logic rx, output int n);
    int k;
    k = 0;
    n = 0;
    @(negedge core_clk);
    while ((rx ? rx_rate_tick : tx_rate_tick) !== 1'b1 && k < 200) begin
      k++;
      @(negedge core_clk);
    end
    do begin
      n++;
      @(negedge core_clk);
    end while ((rx ? rx_rate_tick : tx_rate_tick) !== 1'b1 && n < 200);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    n_mismatch++;
    results();
  end
  initial begin
    int n;
    logic [10:0] clr;
    void'($urandom(88732));
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    rd(12'h004, 32'h0000_1fff, "mask reset");
    rd(12'h00c, 32'h0000_0000, "divisor reset");
    chk("invalid reset", 32'h1, {31'h0, divisor_invalid});
    $display("test reset done");
    for (int i = 0; i < 60; i++) begin
      @(negedge core_clk);
      event_set = uib_pkg::uib_events_type'(11'($urandom));
      rts_line = 1'($urandom);
      cts_line = 1'($urandom);
      lat = lat | event_set;
      @(negedge core_clk);
      event_set = '0;
      repeat (3) @(negedge core_clk);
      rd(12'h000, {19'h0, rts_line, cts_line, lat}, "status");
      chk("irq", {31'h0, |({rts_line, cts_line, lat} & ~mask)}, {31'h0, irq_out});
      clr = 11'($urandom);
      wr(12'h008, {19'h0, 2'b11, clr});
      lat = lat & ~clr;
      mask = 13'($urandom) | 13'($urandom);
      wr(12'h004, {19'h7_ffff, mask});
      rd(12'h004, {19'h0, mask}, "mask");
      rd(12'h008, 32'h0, "clear read");
    end
    fork
      wr(12'h008, {21'h0, 11'h001});
      begin
        @(negedge core_clk);
        event_set = uib_pkg::uib_events_type'(11'h001);
        @(negedge core_clk);
        event_set = '0;
      end
    join
    lat = lat | 11'h001;
    wr(12'h000, 32'hffff_ffff);
    rd(12'h000, {19'h0, rts_line, cts_line, lat}, "status ro");
    rd(12'h020, 32'h0, "unmapped");
    $display("test events done");
    wr(12'h00c, {16'd16, 16'd21});
    @(negedge core_clk);
    chk("rx div", 32'd16, {16'h0, rx_divisor});
    chk("tx div", 32'd21, {16'h0, tx_divisor});
    chk("invalid", 32'h0, {31'h0, divisor_invalid});
    gap(1'b1, n);
    chk("rx gap", 32'd16, n);
    gap(1'b0, n);
    chk("tx gap", 32'd21, n);
    wr(12'h00c, {16'd19, 16'd19});
    gap(1'b0, n);
    chk("ir gap", 32'd19, n);
    gap(1'b1, n);
    chk("ir rx gap", 32'd19, n);
    wr(12'h00c, {16'd40, 16'd15});
    @(negedge core_clk);
    chk("invalid low", 32'h1, {31'h0, divisor_invalid});
    $display("test divisors done");
    results();
  end
endmodule
